// >>> eeprom_sfr_sequencer.sv
// eeprom special function registers and erase/write sequencer
`timescale 1ns/1ps
`include "eeprom_sfr_regs.svh"
module eeprom_sfr_sequencer (
    input wire logic ref_clk,
    input wire logic rstn,
    input eeprom_sfr_pkg::sfr_req_t sfr_req,
    input wire logic serial_irq_enable,
    output logic [7:0] sfr_rdata_q,
    output logic nvm_irq_req_q,
    output logic erase_write_busy_q
);

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    function automatic logic [18:0] pulse_cycles(input logic [7:0] timing);
        logic [8:0] units;
        units = {1'b0, timing} + `EE_TIM_OFFSET;
        return {units, {`EE_PRESCALE_BITS{1'b0}}} - 19'h00001;
    endfunction

    function automatic logic op_known(input logic [3:0] op);
        return (op == `EE_OP_BYTE) || (op == `EE_OP_ROW_ERASE) ||
               (op == `EE_OP_BLOCK_ERASE);
    endfunction

    // ------------------------------------------------------------------------
    // registers and state
    // ------------------------------------------------------------------------
    logic [7:0] eeprom_byte_address_low_q;
    logic [7:0] eeprom_byte_address_high_q;
    logic [7:0] eeprom_data_window_q;
    logic [7:0] erase_write_timing_q;
    logic nvm_irq_flag_q;
    logic nvm_irq_enable_q;
    logic [3:0] operation_select_q;
    logic [7:0] security_byte_q;

    eeprom_sfr_pkg::seq_state_t state_q;
    logic [18:0] phase_cnt_q;
    logic [3:0] tgt_op_q;
    logic [7:0] tgt_low_q;
    logic tgt_sec_q;
    logic [7:0] tgt_data_q;
    logic clr_run_q;
    logic [7:0] clr_idx_q;
    logic [7:0] clr_left_q;

    logic [7:0] arr_rdata;
    logic sel_sec;
    logic sel_arr;
    logic [7:0] cur_byte;
    logic wr_low;
    logic wr_high;
    logic wr_data;
    logic wr_tim;
    logic wr_ctrl;
    logic launch;
    logic phase_end;
    logic done;
    logic byte_erase_end;
    logic byte_write_end;
    logic arr_we;
    logic [7:0] arr_waddr;
    logic [7:0] arr_wdata;
    logic [7:0] ctrl_view;

    // ------------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------------
    assign wr_low = sfr_req.wr && (sfr_req.addr == `EE_OFS_ADDR_LOW);
    assign wr_high = sfr_req.wr && (sfr_req.addr == `EE_OFS_ADDR_HIGH);
    assign wr_data = sfr_req.wr && (sfr_req.addr == `EE_OFS_DATA);
    assign wr_tim = sfr_req.wr && (sfr_req.addr == `EE_OFS_TIMING);
    assign wr_ctrl = sfr_req.wr && (sfr_req.addr == `EE_OFS_CTRL);

    assign sel_sec = (eeprom_byte_address_high_q == `EE_SEC_ADDR_HIGH) &&
                     (eeprom_byte_address_low_q == `EE_SEC_ADDR_LOW);
    assign sel_arr = (eeprom_byte_address_high_q == `EE_ARRAY_ADDR_HIGH);
    assign cur_byte = sel_sec ? security_byte_q :
                      (sel_arr ? arr_rdata : `EE_UNMAPPED);

    // a byte write to an address that holds no cell would burn a pulse for nothing
    assign launch = wr_data && !erase_write_busy_q && op_known(operation_select_q) &&
                    ((operation_select_q != `EE_OP_BYTE) || sel_arr || sel_sec);

    assign phase_end = (state_q != eeprom_sfr_pkg::ST_IDLE) && (phase_cnt_q == 19'h00000);
    assign done = phase_end &&
                  ((state_q == eeprom_sfr_pkg::ST_WRITE) ||
                   (tgt_op_q == `EE_OP_BLOCK_ERASE));
    assign byte_erase_end = phase_end && (state_q == eeprom_sfr_pkg::ST_ERASE) &&
                            (tgt_op_q == `EE_OP_BYTE);
    assign byte_write_end = phase_end && (state_q == eeprom_sfr_pkg::ST_WRITE) &&
                            (tgt_op_q == `EE_OP_BYTE);

    // ------------------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            eeprom_byte_address_low_q <= `EE_RST_ADDR_LOW;
            eeprom_byte_address_high_q <= `EE_RST_ADDR_HIGH;
            erase_write_timing_q <= `EE_RST_TIMING;
        end else begin
            if (wr_low) begin
                eeprom_byte_address_low_q <= sfr_req.wdata;
            end
            if (wr_high) begin
                eeprom_byte_address_high_q <= sfr_req.wdata;
            end
            if (wr_tim) begin
                erase_write_timing_q <= sfr_req.wdata;
            end
        end
    end

    // data window keeps the last value software wrote; ignored while busy
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            eeprom_data_window_q <= `EE_RST_DATA;
        end else if (wr_data && !erase_write_busy_q) begin
            eeprom_data_window_q <= sfr_req.wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            nvm_irq_enable_q <= 1'b0;
            operation_select_q <= `EE_OP_BYTE;
        end else if (wr_ctrl) begin
            nvm_irq_enable_q <= sfr_req.wdata[`EE_BIT_IRQ_EN];
            operation_select_q <= sfr_req.wdata[`EE_OP_MSB:0];
        end
    end

    // completion wins over a software clear in the same cycle
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            nvm_irq_flag_q <= 1'b0;
        end else if (done) begin
            nvm_irq_flag_q <= 1'b1;
        end else if (wr_ctrl) begin
            nvm_irq_flag_q <= sfr_req.wdata[`EE_BIT_IRQ_FLAG];
        end
    end

    // ------------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state_q <= eeprom_sfr_pkg::ST_IDLE;
            phase_cnt_q <= 19'h00000;
            erase_write_busy_q <= 1'b0;
        end else begin
            case (state_q)
                eeprom_sfr_pkg::ST_IDLE: begin
                    if (launch) begin
                        erase_write_busy_q <= 1'b1;
                        phase_cnt_q <= pulse_cycles(erase_write_timing_q);
                        if ((operation_select_q == `EE_OP_BYTE) &&
                            (cur_byte == `EE_ERASED)) begin
                            state_q <= eeprom_sfr_pkg::ST_WRITE;
                        end else begin
                            state_q <= eeprom_sfr_pkg::ST_ERASE;
                        end
                    end
                end
                eeprom_sfr_pkg::ST_ERASE: begin
                    if (phase_end) begin
                        if (tgt_op_q == `EE_OP_BLOCK_ERASE) begin
                            state_q <= eeprom_sfr_pkg::ST_IDLE;
                            erase_write_busy_q <= 1'b0;
                        end else begin
                            state_q <= eeprom_sfr_pkg::ST_WRITE;
                            phase_cnt_q <= pulse_cycles(erase_write_timing_q);
                        end
                    end else begin
                        phase_cnt_q <= phase_cnt_q - 19'h00001;
                    end
                end
                eeprom_sfr_pkg::ST_WRITE: begin
                    if (phase_end) begin
                        state_q <= eeprom_sfr_pkg::ST_IDLE;
                        erase_write_busy_q <= 1'b0;
                    end else begin
                        phase_cnt_q <= phase_cnt_q - 19'h00001;
                    end
                end
                default: begin
                    state_q <= eeprom_sfr_pkg::ST_IDLE;
                    erase_write_busy_q <= 1'b0;
                end
            endcase
        end
    end

    // target is frozen at launch so later register writes cannot redirect it
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            tgt_op_q <= `EE_OP_BYTE;
            tgt_low_q <= `EE_RST_ADDR_LOW;
            tgt_sec_q <= 1'b0;
            tgt_data_q <= `EE_ERASED;
        end else if (launch) begin
            tgt_op_q <= operation_select_q;
            tgt_low_q <= eeprom_byte_address_low_q;
            tgt_sec_q <= sel_sec;
            tgt_data_q <= sfr_req.wdata;
        end
    end

    // ------------------------------------------------------------------------
    // row and block clearing
    // ------------------------------------------------------------------------
    // one cell per cycle; 256 cycles fit well inside the shortest erase phase
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            clr_run_q <= 1'b0;
            clr_idx_q <= 8'h00;
            clr_left_q <= 8'h00;
        end else if (launch && (operation_select_q == `EE_OP_ROW_ERASE)) begin
            clr_run_q <= 1'b1;
            clr_idx_q <= {eeprom_byte_address_low_q[7:3], 3'b000};
            clr_left_q <= `EE_ROW_LAST;
        end else if (launch && (operation_select_q == `EE_OP_BLOCK_ERASE)) begin
            clr_run_q <= 1'b1;
            clr_idx_q <= 8'h00;
            clr_left_q <= `EE_BLOCK_LAST;
        end else if (clr_run_q) begin
            clr_idx_q <= clr_idx_q + 8'h01;
            clr_left_q <= clr_left_q - 8'h01;
            clr_run_q <= (clr_left_q != 8'h00);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            security_byte_q <= `EE_ERASED;
        end else if (done && (tgt_op_q == `EE_OP_BLOCK_ERASE)) begin
            security_byte_q <= `EE_ERASED;
        end else if (byte_erase_end && tgt_sec_q) begin
            security_byte_q <= `EE_ERASED;
        end else if (byte_write_end && tgt_sec_q) begin
            security_byte_q <= tgt_data_q;
        end
    end

    // ------------------------------------------------------------------------
    // cell array
    // ------------------------------------------------------------------------
    always_comb begin
        arr_we = 1'b0;
        arr_waddr = tgt_low_q;
        arr_wdata = `EE_ERASED;
        if (clr_run_q) begin
            arr_we = 1'b1;
            arr_waddr = clr_idx_q;
        end else if (byte_erase_end && !tgt_sec_q) begin
            arr_we = 1'b1;
        end else if (byte_write_end && !tgt_sec_q) begin
            arr_we = 1'b1;
            arr_wdata = tgt_data_q;
        end
    end

    eeprom_byte_array u_array (
        .ref_clk(ref_clk),
        .we(arr_we),
        .waddr(arr_waddr),
        .wdata(arr_wdata),
        .raddr(eeprom_byte_address_low_q),
        .rdata_q(arr_rdata)
    );

    // ------------------------------------------------------------------------
    // read back and interrupt
    // ------------------------------------------------------------------------
    assign ctrl_view = {nvm_irq_flag_q, nvm_irq_enable_q, erase_write_busy_q,
                        1'b0, operation_select_q};

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            sfr_rdata_q <= 8'h00;
        end else begin
            case (sfr_req.addr)
                `EE_OFS_ADDR_LOW: sfr_rdata_q <= eeprom_byte_address_low_q;
                `EE_OFS_ADDR_HIGH: sfr_rdata_q <= eeprom_byte_address_high_q;
                `EE_OFS_DATA: begin
                    // no cell access while busy or outside byte mode
                    if (!erase_write_busy_q && (operation_select_q == `EE_OP_BYTE)) begin
                        sfr_rdata_q <= cur_byte;
                    end else begin
                        sfr_rdata_q <= eeprom_data_window_q;
                    end
                end
                `EE_OFS_TIMING: sfr_rdata_q <= erase_write_timing_q;
                `EE_OFS_CTRL: sfr_rdata_q <= ctrl_view;
                default: sfr_rdata_q <= `EE_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            nvm_irq_req_q <= 1'b0;
        end else begin
            nvm_irq_req_q <= nvm_irq_flag_q && nvm_irq_enable_q &&
                             serial_irq_enable;
        end
    end
endmodule

// >>> eeprom_sfr_regs.svh
// register offsets, field positions, reset values and timing counts for the eeprom sequencer
`ifndef EEPROM_SFR_REGS_SVH
`define EEPROM_SFR_REGS_SVH

// ----------------------------------------------------------------------------
// special function register addresses
// ----------------------------------------------------------------------------
`define EE_OFS_ADDR_LOW 8'hf2
`define EE_OFS_ADDR_HIGH 8'hf3
`define EE_OFS_DATA 8'hf4
`define EE_OFS_TIMING 8'hf5
`define EE_OFS_CTRL 8'hf6

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define EE_RST_ADDR_HIGH 8'h80
`define EE_RST_ADDR_LOW 8'h00
`define EE_RST_TIMING 8'h08
`define EE_RST_DATA 8'h00

// ----------------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------------
`define EE_BIT_IRQ_FLAG 7
`define EE_BIT_IRQ_EN 6
`define EE_BIT_BUSY 5
`define EE_OP_MSB 3
`define EE_OP_BYTE 4'h0
`define EE_OP_ROW_ERASE 4'hc
`define EE_OP_BLOCK_ERASE 4'ha

// ----------------------------------------------------------------------------
// addressing and data values
// ----------------------------------------------------------------------------
`define EE_SEC_ADDR_HIGH 8'h80
`define EE_SEC_ADDR_LOW 8'h00
`define EE_ARRAY_ADDR_HIGH 8'h00
`define EE_ERASED 8'h00
`define EE_UNMAPPED 8'h00
`define EE_ROW_LAST 8'h07
`define EE_BLOCK_LAST 8'hff

// ----------------------------------------------------------------------------
// timing: one phase lasts (timing + offset) * 2^prescale oscillator cycles
// ----------------------------------------------------------------------------
`define EE_TIM_OFFSET 9'h002
`define EE_PRESCALE_BITS 10

`endif

// >>> eeprom_sfr_pkg.sv
// types shared by the eeprom sequencer files
package eeprom_sfr_pkg;

    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ERASE,
        ST_WRITE
    } seq_state_t;

endpackage

// >>> eeprom_byte_array.sv
// 256 x 8 eeprom cell array with registered read data
`timescale 1ns/1ps
module eeprom_byte_array (
    input wire logic ref_clk,
    input wire logic we,
    input wire logic [7:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] raddr,
    output logic [7:0] rdata_q
);
    // no reset: contents are non-volatile
    logic [7:0] cells [0:255];

    always_ff @(posedge ref_clk) begin
        if (we) begin
            cells[waddr] <= wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        rdata_q <= cells[raddr];
    end
endmodule

// >>> eeprom_sfr_sequencer_sva.sv
// concurrent checks on the eeprom sequencer ports
`timescale 1ns/1ps
module eeprom_sfr_sequencer_sva (
    input wire logic ref_clk,
    input wire logic rstn,
    input eeprom_sfr_pkg::sfr_req_t sfr_req,
    input wire logic serial_irq_enable,
    input wire logic [7:0] sfr_rdata_q,
    input wire logic nvm_irq_req_q,
    input wire logic erase_write_busy_q
);
    // ------------------------------------------------------------------
    // shadow of the interrupt enable and length of the busy window
    // ------------------------------------------------------------------
    logic en_q;
    logic [19:0] busy_cnt_q;
    always_ff @(posedge ref_clk) begin
        if (!rstn)
            en_q <= 1'b0;
        else if (sfr_req.wr && sfr_req.addr == 8'hf6)
            en_q <= sfr_req.wdata[6];
    end
    always_ff @(posedge ref_clk) begin
        if (!rstn || !erase_write_busy_q)
            busy_cnt_q <= '0;
        else
            busy_cnt_q <= busy_cnt_q + 20'h00001;
    end
    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    a_irq_needs_serial: assert property (
        $past(rstn) && nvm_irq_req_q |-> $past(serial_irq_enable))
        else $error("irq request without serial enable");
    a_busy_needs_launch: assert property (
        $rose(erase_write_busy_q) |-> $past(sfr_req.wr && sfr_req.addr == 8'hf4))
        else $error("busy rose without a data write");
    a_busy_min_len: assert property (
        $fell(erase_write_busy_q) |-> busy_cnt_q >= 20'h00800)
        else $error("busy window shorter than one phase");
    a_done_raises_irq: assert property (
        $fell(erase_write_busy_q) && en_q && serial_irq_enable |=> nvm_irq_req_q)
        else $error("no irq request after completion");
    a_irq_gated_off: assert property (
        !en_q |=> !nvm_irq_req_q)
        else $error("irq request while enable is clear");
    a_unmapped_zero: assert property (
        $past(rstn) && !($past(sfr_req.addr) inside {[8'hf2:8'hf6]}) |-> sfr_rdata_q == 8'h00)
        else $error("unmapped read not zero");
    a_busy_bit_view: assert property (
        $past(rstn) && $past(sfr_req.addr) == 8'hf6 |-> sfr_rdata_q[5] == $past(erase_write_busy_q))
        else $error("control bit 5 differs from busy");
    a_reserved_bit: assert property (
        $past(sfr_req.addr) == 8'hf6 |-> sfr_rdata_q[4] == 1'b0)
        else $error("reserved control bit reads one");
endmodule

bind eeprom_sfr_sequencer eeprom_sfr_sequencer_sva i_sva (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .sfr_req(sfr_req),
    .serial_irq_enable(serial_irq_enable),
    .sfr_rdata_q(sfr_rdata_q),
    .nvm_irq_req_q(nvm_irq_req_q),
    .erase_write_busy_q(erase_write_busy_q)
);

// >>> eeprom_host_model.sv
// behavioural cpu core reaching the eeprom special function registers
`timescale 1ns/1ps
module eeprom_host_model (
    input wire logic ref_clk,
    input wire logic erase_write_busy_q,
    input wire logic [7:0] sfr_rdata_q,
    output eeprom_sfr_pkg::sfr_req_t sfr_req,
    output logic serial_irq_enable
);
    initial begin
        sfr_req = '0;
        serial_irq_enable = 1'b0;
    end
    task automatic set_serial(input logic v);
        @(posedge ref_clk);
        #1;
        serial_irq_enable = v;
    endtask
    // data is scrambled after the strobe so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        sfr_req = '{wr: 1'b1, addr: a, wdata: d};
        @(posedge ref_clk);
        #1;
        sfr_req.wr = 1'b0;
        sfr_req.wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        #1;
        sfr_req.addr = a;
        repeat (2) @(posedge ref_clk);
        #1;
        d = sfr_rdata_q;
    endtask
    // no sleep or new access until the sequencer is idle
    task automatic wait_idle(output int n);
        n = 0;
        while (erase_write_busy_q === 1'b1 && n < 600000) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
    endtask
    task automatic put_byte(input logic [7:0] hi, lo, d, output int n);
        wr(8'hf3, hi);
        wr(8'hf2, lo);
        wr(8'hf4, d);
        wait_idle(n);
    endtask
endmodule

// >>> eeprom_sfr_sequencer_bench.sv
// self-checking bench for the eeprom sequencer
`timescale 1ns/1ps
module eeprom_sfr_sequencer_bench;
    localparam int UNIT = 1024;
    localparam int PHASE = 2 * UNIT;
    logic ref_clk;
    logic rstn;
    eeprom_sfr_pkg::sfr_req_t sfr_req;
    logic serial_irq_enable;
    logic [7:0] sfr_rdata_q;
    logic nvm_irq_req_q;
    logic erase_write_busy_q;
    int num_errors = 0;
    int checks_done = 0;
    int n;

    eeprom_sfr_sequencer i_dut (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .sfr_req(sfr_req),
        .serial_irq_enable(serial_irq_enable),
        .sfr_rdata_q(sfr_rdata_q),
        .nvm_irq_req_q(nvm_irq_req_q),
        .erase_write_busy_q(erase_write_busy_q)
    );
    eeprom_host_model i_host (
        .ref_clk(ref_clk),
        .erase_write_busy_q(erase_write_busy_q),
        .sfr_rdata_q(sfr_rdata_q),
        .sfr_req(sfr_req),
        .serial_irq_enable(serial_irq_enable)
    );

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------------
    // compare helpers
    // ------------------------------------------------------------------
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic chkn(input int got, input int exp, input string what);
        checks_done++;
        if (got != exp) begin
            num_errors++;
            $display("[FAIL] %0t %s got %0d exp %0d", $time, what, got, exp);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] exp, input string what);
        logic [7:0] d;
        i_host.rd(a, d);
        chk8(d, exp, what);
    endtask
    task automatic rd_byte(input logic [7:0] hi, lo, exp);
        i_host.wr(8'hf3, hi);
        i_host.wr(8'hf2, lo);
        rc(8'hf4, exp, "array byte");
    endtask
    task automatic give_verdict();
        if (num_errors == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset_values();
        rc(8'hf3, 8'h80, "addr high reset");
        rc(8'hf2, 8'h00, "addr low reset");
        rc(8'hf5, 8'h08, "timing reset");
        rc(8'hf6, 8'h00, "control reset");
        rc(8'hf7, 8'h00, "unmapped read");
    endtask
    task automatic t_reg_access();
        logic [7:0] regs [3] = '{8'hf2, 8'hf3, 8'hf5};
        foreach (regs[i]) begin
            i_host.wr(regs[i], 8'h5c ^ regs[i]);
            rc(regs[i], 8'h5c ^ regs[i], "register readback");
        end
        i_host.wr(8'hf6, 8'hff);
        rc(8'hf6, 8'hcf, "control software bits");
        chk8({7'h0, nvm_irq_req_q}, 8'h00, "irq without serial enable");
        i_host.set_serial(1'b1);
        repeat (2) @(posedge ref_clk);
        #1;
        chk8({7'h0, nvm_irq_req_q}, 8'h01, "software set flag");
        // flag stays set, enable dropped: request must fall
        i_host.wr(8'hf6, 8'h8f);
        repeat (2) @(posedge ref_clk);
        #1;
        chk8({7'h0, nvm_irq_req_q}, 8'h00, "flag with enable clear");
        i_host.wr(8'hf4, 8'h3c);
        chk8({7'h0, erase_write_busy_q}, 8'h00, "unsupported op launched");
        i_host.wr(8'hf6, 8'h40);
        repeat (2) @(posedge ref_clk);
        #1;
        chk8({7'h0, nvm_irq_req_q}, 8'h00, "software clear flag");
        // high address still holds a value that maps no cell
        i_host.wr(8'hf4, 8'h3c);
        chk8({7'h0, erase_write_busy_q}, 8'h00, "unmapped byte write launched");
    endtask
    task automatic t_block_erase();
        i_host.wr(8'hf5, 8'h00);
        i_host.wr(8'hf6, 8'h4a);
        i_host.wr(8'hf4, 8'hee);
        i_host.wait_idle(n);
        chkn(n, PHASE, "block erase length");
        rc(8'hf6, 8'hca, "flag at completion");
        chk8({7'h0, nvm_irq_req_q}, 8'h01, "completion irq");
        i_host.wr(8'hf6, 8'h40);
        rd_byte(8'h00, 8'h00, 8'h00);
        rd_byte(8'h00, 8'hff, 8'h00);
        rd_byte(8'h80, 8'h00, 8'h00);
    endtask
    task automatic t_byte_write();
        i_host.put_byte(8'h00, 8'h10, 8'h5a, n);
        chkn(n, PHASE, "write of erased byte");
        rd_byte(8'h00, 8'h10, 8'h5a);
        i_host.wr(8'hf4, 8'h33);
        i_host.wr(8'hf4, 8'h77);
        rc(8'hf6, 8'he0, "busy bit while busy");
        rc(8'hf4, 8'h33, "data read while busy");
        i_host.wait_idle(n);
        chkn(n, 2 * PHASE - 8, "erase plus write");
        rd_byte(8'h00, 8'h10, 8'h33);
        i_host.put_byte(8'h80, 8'h00, 8'ha5, n);
        chkn(n, PHASE, "security byte write");
        rd_byte(8'h80, 8'h00, 8'ha5);
    endtask
    task automatic t_row_erase();
        i_host.put_byte(8'h00, 8'h1a, 8'h44, n);
        i_host.wr(8'hf2, 8'h1d);
        i_host.wr(8'hf6, 8'h4c);
        i_host.wr(8'hf4, 8'h99);
        i_host.wait_idle(n);
        chkn(n, 2 * PHASE, "row erase length");
        i_host.wr(8'hf6, 8'h40);
        rd_byte(8'h00, 8'h1a, 8'h00);
        rd_byte(8'h00, 8'h10, 8'h33);
        i_host.put_byte(8'h00, 8'h1a, 8'h12, n);
        chkn(n, PHASE, "write after row erase");
        rd_byte(8'h00, 8'h1a, 8'h12);
        i_host.wr(8'hf5, 8'h01);
        i_host.put_byte(8'h00, 8'h1b, 8'h21, n);
        chkn(n, 3 * UNIT, "phase at timing 01");
    endtask

    // ------------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        repeat (20) @(posedge ref_clk);
        #1;
        rstn = 1'b1;
        t_reset_values();
        t_reg_access();
        t_block_erase();
        t_byte_write();
        t_row_erase();
        give_verdict();
    end
    // the phases add up to about 11 x 2048 cycles; leave ample margin
    initial begin
        repeat (40000) @(posedge ref_clk);
        num_errors++;
        give_verdict();
    end
endmodule
